/* File: rtl/ptp_timer.sv */
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ptp_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // avalon-mm slave
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // event outputs
  output logic pwm_timebase_o,
  output logic spi_shift_clk_o,
  output logic match_irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  ptp_pkg::ptp_state_t s_q;
  ptp_pkg::ptp_state_t s_d;
  ptp_pkg::ptp_bus_req_t req;
  logic pre_tick;
  logic count_wr;
  logic match_now;
  logic access;
  logic wr_ok;

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  // true once the postscaler has seen as many matches as the ratio asks
  function automatic logic post_done(input ptp_pkg::ptp_state_t st);
    post_done = (st.post_cnt == st.control[ptp_pkg::CTL_POST_LSB +: 4]);
  endfunction

  // software write; a count write also restarts the postscaler so the
  // next interrupt comes a whole ratio after the new count
  function automatic ptp_pkg::ptp_state_t apply_write(
    input ptp_pkg::ptp_state_t st,
    input logic [2:0] adr,
    input logic [7:0] data
  );
    ptp_pkg::ptp_state_t nx;
    nx = st;
    case (adr)
      ptp_pkg::ADDR_COUNT: begin
        nx.count = data;
        nx.post_cnt = 4'h0;
      end
      ptp_pkg::ADDR_CONTROL: begin
        nx.control = data[6:0];
      end
      ptp_pkg::ADDR_PERIOD: begin
        nx.period = data;
      end
      ptp_pkg::ADDR_IRQ_REQ: begin
        nx.match_flag = data[ptp_pkg::IRQ_MATCH_BIT];
      end
      ptp_pkg::ADDR_IRQ_EN: begin
        nx.match_en = data[ptp_pkg::IRQ_MATCH_BIT];
      end
      default: begin
        nx = st;
      end
    endcase
    apply_write = nx;
  endfunction

  // read view of one word; unmapped words and unused bits read as zero
  function automatic logic [31:0] read_word(
    input ptp_pkg::ptp_state_t st,
    input logic [2:0] adr
  );
    logic [31:0] w;
    w = 32'h0;
    case (adr)
      ptp_pkg::ADDR_COUNT: begin
        w[7:0] = st.count;
      end
      ptp_pkg::ADDR_CONTROL: begin
        w[7:0] = {1'b0, st.control} & ptp_pkg::CTL_MASK;
      end
      ptp_pkg::ADDR_PERIOD: begin
        w[7:0] = st.period;
      end
      ptp_pkg::ADDR_IRQ_REQ: begin
        w[ptp_pkg::IRQ_MATCH_BIT] = st.match_flag;
      end
      ptp_pkg::ADDR_IRQ_EN: begin
        w[ptp_pkg::IRQ_MATCH_BIT] = st.match_en;
      end
      default: begin
        w = 32'h0;
      end
    endcase
    read_word = w;
  endfunction

  // state while reset is held; waitrequest idles high
  function automatic ptp_pkg::ptp_state_t reset_state();
    ptp_pkg::ptp_state_t st;
    st = '0;
    st.count = ptp_pkg::RST_COUNT;
    st.control = ptp_pkg::RST_CONTROL;
    st.period = ptp_pkg::RST_PERIOD;
    st.waitreq = 1'b1;
    reset_state = st;
  endfunction

  // a count write also clears the prescaler, so the first tick is whole
  ptp_prescale u_prescale (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .run_i(s_q.control[ptp_pkg::CTL_ON_BIT]),
    .clear_i(count_wr),
    .select_i(s_q.control[ptp_pkg::CTL_PS_LSB +: 2]),
    .tick_o(pre_tick)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    req.address = avs_address_i;
    req.read = avs_read_i;
    req.write = avs_write_i;
    req.writedata = avs_writedata_i;
    req.byteenable = avs_byteenable_i;
    s_d = s_q;
    // one wait cycle: request seen with waitrequest high, taken next edge
    access = (req.read || req.write) && s_q.waitreq;
    wr_ok = access && req.write && req.byteenable[0];
    count_wr = wr_ok && (req.address == ptp_pkg::ADDR_COUNT);
    s_d.waitreq = !access;
    s_d.rdata = 32'h0;
    match_now = 1'b0;
    s_d.match_pulse = 1'b0;

    // ****************************************************************
    // timer count and postscaler
    // ****************************************************************
    // the count only moves on a prescaler tick while the timer is on
    if (s_q.control[ptp_pkg::CTL_ON_BIT] && pre_tick) begin
      if (s_q.count == s_q.period) begin
        match_now = 1'b1;
        s_d.count = 8'h00;
      end else begin
        s_d.count = s_q.count + 8'h01;
      end
    end
    s_d.match_pulse = match_now;

    if (match_now) begin
      if (post_done(s_q)) begin
        s_d.post_cnt = 4'h0;
      end else begin
        s_d.post_cnt = s_q.post_cnt + 4'h1;
      end
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    // a write to count wins over counting in the same cycle
    if (wr_ok) begin
      s_d = apply_write(s_d, req.address, req.writedata[7:0]);
    end

    // ****************************************************************
    // match flag and interrupt
    // ****************************************************************
    // hardware set wins over a software clear in the same cycle
    if (match_now && post_done(s_q)) begin
      s_d.match_flag = 1'b1;
    end
    s_d.irq = s_d.match_flag && s_d.match_en;

    // ****************************************************************
    // read data
    // ****************************************************************
    // read data stand for the one cycle in which waitrequest is low
    if (access && req.read) begin
      s_d.rdata = read_word(s_q, req.address);
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= reset_state();
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.waitreq;
  // the pwm and spi event outputs share one flop so they can never disagree
  assign pwm_timebase_o = s_q.match_pulse;
  assign spi_shift_clk_o = s_q.match_pulse;
  assign match_irq_o = s_q.irq;

endmodule

/* File: shared/ptp_pkg.sv */
package ptp_pkg;

  // ****************************************************************
  // register map (word offsets on avalon, byte address = index * 4)
  // ****************************************************************
  localparam logic [2:0] ADDR_COUNT = 3'h0;
  localparam logic [2:0] ADDR_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_PERIOD = 3'h2;
  localparam logic [2:0] ADDR_IRQ_REQ = 3'h3;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h4;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_PS_LSB = 0;
  localparam int CTL_ON_BIT = 2;
  localparam int CTL_POST_LSB = 3;
  localparam int IRQ_MATCH_BIT = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [6:0] RST_CONTROL = 7'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] CTL_MASK = 8'h7F;

  // prescale divisors 1, 4, 16, 16 minus one
  localparam logic [3:0] PRE_DIV1 = 4'h0;
  localparam logic [3:0] PRE_DIV4 = 4'h3;
  localparam logic [3:0] PRE_DIV16 = 4'hF;

  typedef struct packed {
    logic [7:0] count;
    logic [6:0] control;
    logic [7:0] period;
    logic match_flag;
    logic match_en;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic match_pulse;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
  } ptp_state_t;

  typedef struct packed {
    logic [2:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ptp_bus_req_t;

endpackage

/* File: rtl/ptp_prescale.sv */
`timescale 1ns/1ps
module ptp_prescale (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // control
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [1:0] select_i,
  // tick out
  output logic tick_o
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] limit;

  function automatic logic [3:0] div_limit(input logic [1:0] sel);
    case (sel)
      2'h0: div_limit = ptp_pkg::PRE_DIV1;
      2'h1: div_limit = ptp_pkg::PRE_DIV4;
      default: div_limit = ptp_pkg::PRE_DIV16;
    endcase
  endfunction

  always_comb begin
    limit = div_limit(select_i);
    tick_o = run_i && (cnt_q >= limit);
    cnt_d = cnt_q;
    if (clear_i || !run_i) begin
      cnt_d = 4'h0;
    end else if (tick_o) begin
      cnt_d = 4'h0;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

/* File: testbench/ptp_timer_props.sv */
`timescale 1ns/1ps
// ****
// checks
// ****
module ptp_timer_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic pwm_timebase_o,
  input wire logic spi_shift_clk_o,
  input wire logic match_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_spi_same: assert property (spi_shift_clk_o == pwm_timebase_o)
    else $error("spi clock differs");
  a_wait_low: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_rd_idle: assert property (avs_waitrequest_o |-> avs_readdata_o == 0)
    else $error("read data outside answer");
  a_rd_upper: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ctl_top: assert property (!avs_waitrequest_o && avs_read_i &&
    avs_address_i == 3'h1 |-> !avs_readdata_o[7]) else $error("bit 7 set");
  a_irq_off: assert property (avs_write_i && avs_waitrequest_o &&
    avs_address_i == 3'h4 && avs_byteenable_i[0] && !avs_writedata_i[1]
    |-> ##2 !match_irq_o) else $error("irq while disabled");
  a_timer_off: assert property (avs_write_i && avs_waitrequest_o &&
    avs_address_i == 3'h1 && avs_byteenable_i[0] && !avs_writedata_i[2]
    |-> ##5 !pwm_timebase_o [*8]) else $error("pulse while off");
  c_pulse: cover property (pwm_timebase_o);
  c_irq: cover property ($rose(match_irq_o));
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule
bind ptp_timer ptp_timer_props u_props (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .pwm_timebase_o(pwm_timebase_o),
  .spi_shift_clk_o(spi_shift_clk_o),
  .match_irq_o(match_irq_o)
);

/* File: testbench/ptp_timer_tb.sv */
`timescale 1ns/1ps
module ptp_timer_tb;
  logic clk_i = 0;
  logic reset_i = 1;
  logic [2:0] adr = 0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wd = 0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic [31:0] q;
  logic pwm, spi, irq, wt;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  always #20 clk_i = ~clk_i;
  ptp_timer DUT (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .pwm_timebase_o(pwm),
    .spi_shift_clk_o(spi), .match_irq_o(irq));
  // ****
  // bus tasks
  // ****
  task automatic acc(input logic [2:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    // no cycle count is assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task rchk(input logic [2:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    chk($sformatf("reg %0d", a), {24'h0, e}, q);
  endtask
  // interval between two match pulses, in clocks
  task gap(output int g);
    n = 0;
    while (pwm !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    g = 0;
    do begin
      @(posedge clk_i);
      g++;
    end while (pwm !== 1'b1 && g < 5000);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    give_verdict;
  end
  // ****
  // tests
  // ****
  initial begin
    int g;
    int h;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rchk(3'h0, 8'h00);
    rchk(3'h1, 8'h00);
    rchk(3'h2, 8'hFF);
    rchk(3'h5, 8'h00);
    acc(3'h1, 1'b1, 8'hFF);
    rchk(3'h1, 8'h7F);
    // a write without the low byte lane must leave the period alone
    be <= 4'h0;
    acc(3'h2, 1'b1, 8'h55);
    be <= 4'hF;
    rchk(3'h2, 8'hFF);
    $display("register test done");
    acc(3'h2, 1'b1, 8'h03);
    for (int s = 0; s < 4; s++) begin
      acc(3'h1, 1'b1, 8'h04 | s[7:0]);
      acc(3'h0, 1'b1, 8'h00);
      gap(g);
      chk("match gap", 4 * (s == 0 ? 1 : s == 1 ? 4 : 16), g);
    end
    $display("prescale test done");
    acc(3'h4, 1'b1, 8'h02);
    for (int p = 0; p < 16; p += 15) begin
      acc(3'h1, 1'b1, {1'b0, p[3:0], 3'h0});
      acc(3'h3, 1'b1, 8'h00);
      acc(3'h0, 1'b1, 8'h00);
      acc(3'h1, 1'b1, {1'b0, p[3:0], 3'h4});
      n = 0;
      g = 0;
      h = 0;
      while (irq !== 1'b1 && n < 500) begin
        @(posedge clk_i);
        n++;
        if (pwm === 1'b1) g++;
        if (spi === 1'b1) h++;
      end
      chk("irq raised", 32'h1, {31'h0, irq});
      chk("pulses to irq", p + 1, g);
      chk("spi pulses", p + 1, h);
      rchk(3'h3, 8'h02);
    end
    acc(3'h4, 1'b1, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("irq off", 32'h0, {31'h0, irq});
    rchk(3'h3, 8'h02);
    $display("postscale test done");
    // reset in mid-run must bring back the reset values
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rchk(3'h2, 8'hFF);
    rchk(3'h3, 8'h00);
    chk("irq after reset", 32'h0, {31'h0, irq});
    $display("reset test done");
    give_verdict;
  end
endmodule
